// ===== shared/adcri_map.svh
// Register offsets, field positions, reset values and timing counts
// of the converter result register interface.
// Assumes inclusion by bare name from the modules.
`ifndef ADCRI_MAP_SVH
`define ADCRI_MAP_SVH

// ****************************************************************
// Byte offsets on the register bus
// ****************************************************************
`define ADCRI_OFS_MAIN_CTRL 8'h00
`define ADCRI_OFS_FMT_CLK_REF 8'h04
`define ADCRI_OFS_TRIG_SEL 8'h08
`define ADCRI_OFS_RES_HIGH 8'h0C
`define ADCRI_OFS_RES_LOW 8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define ADCRI_CHAN_MSB 6
`define ADCRI_CHAN_LSB 2
`define ADCRI_GO_BIT 1
`define ADCRI_ON_BIT 0
`define ADCRI_FMT_BIT 7
`define ADCRI_CLKSEL_MSB 6
`define ADCRI_CLKSEL_LSB 4
`define ADCRI_PREF_MSB 1
`define ADCRI_PREF_LSB 0
`define ADCRI_TRIG_MSB 7
`define ADCRI_TRIG_LSB 4

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define ADCRI_CTRL_RST 8'h00
`define ADCRI_RES_RST 8'h00
`define ADCRI_RC_DIV 7'h10
`define ADCRI_RESULT_BITS 10
`define ADCRI_TRIG_SRCS 11

`endif

// ===== shared/adcri_pkg.sv
// Types shared by the converter result register interface modules.
// Assumes the map header sits beside it on the include path.
package adcri_pkg;

  typedef enum logic [1:0] {
    ADCRI_IDLE = 2'b01,
    ADCRI_CONV = 2'b10
  } adcri_conv_e;

  typedef enum logic [1:0] {
    ADCRI_BUS_WAIT = 2'b01,
    ADCRI_BUS_ACK = 2'b10
  } adcri_bus_e;

  typedef logic [7:0] adcri_byte_t;

endpackage

// ===== rtl/adcri_justify.sv
// Places a ten-bit conversion result into the two result bytes.
// Assumes the caller registers the outputs on a conversion end.
`default_nettype none
`timescale 1ns/1ps
`include "adcri_map.svh"

module adcri_justify
  import adcri_pkg::*;
(
  // Result and layout
  input wire logic [`ADCRI_RESULT_BITS-1:0] i_result,
  input wire logic i_right_just,
  // Result bytes
  output adcri_byte_t o_high,
  output adcri_byte_t o_low
);

  always_comb begin
    if (i_right_just) begin
      o_high = {6'h00, i_result[9:8]};
      o_low = i_result[7:0];
    end else begin
      o_high = i_result[9:2];
      o_low = {i_result[1:0], 6'h00};
    end
  end

endmodule
`default_nettype wire

// ===== rtl/adcri_avmm.sv
// Avalon-MM slave handshake: one wait cycle, then answer.
// Assumes the master holds its request until waitrequest is low.
`default_nettype none
`timescale 1ns/1ps
`include "adcri_map.svh"

module adcri_avmm
  import adcri_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Avalon-MM side
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic o_waitrequest,
  output logic [31:0] o_readdata,
  // Register side
  input wire logic [7:0] i_rdata,
  output logic o_wr_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);

  typedef struct packed {
    adcri_bus_e st;
    logic [31:0] rdata;
  } adcri_bus_s;

  adcri_bus_s r;
  adcri_bus_s next_r;

  // ****************************************************************
  // Handshake
  // ****************************************************************
  always_comb begin
    next_r = r;
    unique case (r.st)
      ADCRI_BUS_WAIT: begin
        if (i_read || i_write) begin
          next_r.st = ADCRI_BUS_ACK;
          next_r.rdata = {24'h000000, i_rdata};
        end
      end
      ADCRI_BUS_ACK: begin
        next_r.st = ADCRI_BUS_WAIT;
      end
      default: begin
        next_r.st = ADCRI_BUS_WAIT;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '{st: ADCRI_BUS_WAIT, rdata: 32'h00000000};
    end else begin
      r <= next_r;
    end
  end

  assign o_waitrequest = (r.st != ADCRI_BUS_ACK);
  assign o_readdata = r.rdata;
  assign o_wr_en = (r.st == ADCRI_BUS_ACK) && i_write && i_byteenable[0];
  assign o_addr = i_address;
  assign o_wdata = i_writedata[7:0];

endmodule
`default_nettype wire

// ===== rtl/adcri_top.sv
// Register side of a ten-bit successive-approximation converter.
// Assumes an analog core that converts on o_conv_start and answers
// with i_conv_done and i_conv_result; software on Avalon-MM.
//
// Chosen here: register access over Avalon-MM and the register offsets.
`default_nettype none
`timescale 1ns/1ps
`include "adcri_map.svh"

module adcri_top
  import adcri_pkg::*;
#(
  parameter int RESULT_BITS = `ADCRI_RESULT_BITS
) (
  // Clock and resets
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_soft_rstn,
  // Avalon-MM slave
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic o_waitrequest,
  output logic [31:0] o_readdata,
  // Analog core
  input wire logic i_conv_done,
  input wire logic [RESULT_BITS-1:0] i_conv_result,
  input wire logic [`ADCRI_TRIG_SRCS-1:0] i_trig_src,
  output logic o_conv_start,
  output logic o_converter_on,
  output logic [4:0] o_channel_selector,
  output logic [1:0] o_positive_reference_select,
  output logic o_conv_tick
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    adcri_conv_e st;
    logic [4:0] chan;
    logic go;
    logic on;
    logic fmt;
    logic [2:0] clk_sel;
    logic [1:0] pref;
    logic [3:0] trig_sel;
    adcri_byte_t res_high;
    adcri_byte_t res_low;
    logic start;
    logic trig_prev;
    logic [6:0] div_cnt;
    logic tick;
  } adcri_state_s;

  adcri_state_s r;
  adcri_state_s next_r;

  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  adcri_byte_t just_high;
  adcri_byte_t just_low;
  logic trig_now;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [6:0] clk_divisor(input logic [2:0] sel);
    logic [6:0] d;
    d = `ADCRI_RC_DIV;
    case (sel)
      3'h0: d = 7'h02;
      3'h1: d = 7'h08;
      3'h2: d = 7'h20;
      3'h4: d = 7'h04;
      3'h5: d = 7'h10;
      3'h6: d = 7'h40;
      default: d = `ADCRI_RC_DIV;
    endcase
    return d;
  endfunction

  function automatic logic trig_pick(input logic [3:0] sel,
                                     input logic [`ADCRI_TRIG_SRCS-1:0] src);
    logic t;
    t = 1'b0;
    if (sel != 4'h0 && sel < 4'hB) begin
      t = src[sel];
    end
    return t;
  endfunction

  // ****************************************************************
  // Bus slave and result layout
  // ****************************************************************
  adcri_avmm u_avmm (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_address(i_address),
    .i_read(i_read),
    .i_write(i_write),
    .i_byteenable(i_byteenable),
    .i_writedata(i_writedata),
    .o_waitrequest(o_waitrequest),
    .o_readdata(o_readdata),
    .i_rdata(rdata),
    .o_wr_en(wr_en),
    .o_addr(addr),
    .o_wdata(wdata)
  );

  adcri_justify u_justify (
    .i_result(i_conv_result),
    .i_right_just(r.fmt),
    .o_high(just_high),
    .o_low(just_low)
  );

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always_comb begin
    rdata = 8'h00;
    case (addr)
      `ADCRI_OFS_MAIN_CTRL: rdata = {1'b0, r.chan, r.go, r.on};
      `ADCRI_OFS_FMT_CLK_REF: rdata = {r.fmt, r.clk_sel, 2'b00, r.pref};
      `ADCRI_OFS_TRIG_SEL: rdata = {r.trig_sel, 4'h0};
      `ADCRI_OFS_RES_HIGH: rdata = r.res_high;
      `ADCRI_OFS_RES_LOW: rdata = r.res_low;
      default: rdata = 8'h00;
    endcase
  end

  assign trig_now = trig_pick(r.trig_sel, i_trig_src);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    next_r.tick = 1'b0;
    next_r.trig_prev = trig_now;

    // Conversion clock divider
    if (r.div_cnt >= clk_divisor(r.clk_sel) - 7'h01) begin
      next_r.div_cnt = 7'h00;
      next_r.tick = r.on;
    end else begin
      next_r.div_cnt = r.div_cnt + 7'h01;
    end

    // Software writes; only implemented bits store
    if (wr_en) begin
      case (addr)
        `ADCRI_OFS_MAIN_CTRL: begin
          next_r.chan = wdata[`ADCRI_CHAN_MSB:`ADCRI_CHAN_LSB];
          next_r.go = wdata[`ADCRI_GO_BIT];
          next_r.on = wdata[`ADCRI_ON_BIT];
        end
        `ADCRI_OFS_FMT_CLK_REF: begin
          next_r.fmt = wdata[`ADCRI_FMT_BIT];
          next_r.clk_sel = wdata[`ADCRI_CLKSEL_MSB:`ADCRI_CLKSEL_LSB];
          next_r.pref = wdata[`ADCRI_PREF_MSB:`ADCRI_PREF_LSB];
        end
        `ADCRI_OFS_TRIG_SEL: next_r.trig_sel = wdata[`ADCRI_TRIG_MSB:`ADCRI_TRIG_LSB];
        `ADCRI_OFS_RES_HIGH: next_r.res_high = wdata;
        `ADCRI_OFS_RES_LOW: next_r.res_low = wdata;
        default: next_r.go = next_r.go;
      endcase
    end

    // Rising edge of selected trigger source sets go
    if (trig_now && !r.trig_prev && r.on) begin
      next_r.go = 1'b1;
    end

    // Conversion sequencing; no discharge step is ever issued
    unique case (r.st)
      ADCRI_IDLE: begin
        if (next_r.go && next_r.on) begin
          next_r.st = ADCRI_CONV;
          next_r.start = 1'b1;
        end else begin
          next_r.go = 1'b0;
        end
      end
      ADCRI_CONV: begin
        if (!next_r.on || !next_r.go) begin
          next_r.st = ADCRI_IDLE;
          next_r.go = 1'b0;
        end else if (i_conv_done) begin
          next_r.st = ADCRI_IDLE;
          next_r.go = 1'b0;
          next_r.res_high = just_high;
          next_r.res_low = just_low;
        end
      end
      default: begin
        next_r.st = ADCRI_IDLE;
        next_r.go = 1'b0;
      end
    endcase

    // Soft reset clears control but keeps result bytes
    if (!i_soft_rstn) begin
      next_r.st = ADCRI_IDLE;
      next_r.chan = 5'h00;
      next_r.go = 1'b0;
      next_r.on = 1'b0;
      next_r.fmt = 1'b0;
      next_r.clk_sel = 3'h0;
      next_r.pref = 2'h0;
      next_r.trig_sel = 4'h0;
      next_r.start = 1'b0;
      next_r.tick = 1'b0;
      next_r.div_cnt = 7'h00;
      next_r.res_high = r.res_high;
      next_r.res_low = r.res_low;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      r.st <= ADCRI_IDLE;
      r.chan <= 5'h00;
      r.go <= 1'b0;
      r.on <= 1'b0;
      r.fmt <= 1'b0;
      r.clk_sel <= 3'h0;
      r.pref <= 2'h0;
      r.trig_sel <= 4'h0;
      r.res_high <= `ADCRI_RES_RST;
      r.res_low <= `ADCRI_RES_RST;
      r.start <= 1'b0;
      r.trig_prev <= 1'b0;
      r.div_cnt <= 7'h00;
      r.tick <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_conv_start = r.start;
  assign o_converter_on = r.on;
  assign o_channel_selector = r.chan;
  assign o_positive_reference_select = r.pref;
  assign o_conv_tick = r.tick;

endmodule
`default_nettype wire

// ===== tb/adcri_assertions.sv
// Checker of the converter register interface top ports.
// Assumes binding to adcri_top; one clock domain.
`default_nettype none
`timescale 1ns/1ps
`include "adcri_map.svh"

module adcri_assertions
  import adcri_pkg::*;
(
  // Clock and resets
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_soft_rstn,
  // Register bus
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  input wire logic o_waitrequest,
  input wire logic [31:0] o_readdata,
  // Converter control
  input wire logic o_conv_start,
  input wire logic o_converter_on,
  input wire logic [4:0] o_channel_selector
);
  // ****************************************************************
  // Helpers and properties
  // ****************************************************************
  logic rd_ack;
  logic wr_main;
  assign rd_ack = i_read && !o_waitrequest;
  assign wr_main = i_write && !o_waitrequest && i_byteenable[0] && i_soft_rstn
    && (i_address == `ADCRI_OFS_MAIN_CTRL);

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  a_wait_one_cycle: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("waitrequest not low after one wait cycle");
  a_wait_one_pulse: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_rd_upper_zero: assert property (rd_ack |-> o_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_unmapped_zero: assert property (rd_ack && !(i_address inside {`ADCRI_OFS_MAIN_CTRL,
    `ADCRI_OFS_FMT_CLK_REF, `ADCRI_OFS_TRIG_SEL, `ADCRI_OFS_RES_HIGH, `ADCRI_OFS_RES_LOW})
    |-> o_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_main_top_zero: assert property (rd_ack && i_address == `ADCRI_OFS_MAIN_CTRL
    |-> !o_readdata[7])
    else $error("main control top bit not zero");
  a_fmt_gap_zero: assert property (rd_ack && i_address == `ADCRI_OFS_FMT_CLK_REF
    |-> o_readdata[3:2] == 2'b00)
    else $error("format register bits 3:2 not zero");
  a_trig_low_zero: assert property (rd_ack && i_address == `ADCRI_OFS_TRIG_SEL
    |-> o_readdata[3:0] == 4'h0)
    else $error("trigger register low bits not zero");
  a_main_fields: assert property (wr_main |=> o_converter_on == $past(i_writedata[0])
    && o_channel_selector == $past(i_writedata[6:2]))
    else $error("enable or channel not taken from write");
  a_go_starts: assert property (wr_main && i_writedata[1:0] == 2'b11 |=> o_conv_start)
    else $error("go with enable did not start");
  a_go_refused: assert property (wr_main && !i_writedata[0] |=> !o_conv_start)
    else $error("conversion started while disabled");
  a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
    else $error("start longer than one cycle");
  a_soft_clears: assert property (!i_soft_rstn |=> !o_converter_on)
    else $error("soft reset left converter on");
endmodule

bind adcri_top adcri_assertions i_adcri_assertions (.i_mclk, .i_rstn, .i_soft_rstn,
  .i_address, .i_read, .i_write, .i_byteenable, .i_writedata, .o_waitrequest,
  .o_readdata, .o_conv_start, .o_converter_on, .o_channel_selector);
`default_nettype wire

// ===== tb/adcri_top_tb.sv
// Self-checking bench of the converter register interface.
// Assumes adcri_top and its checker compiled before it.
`default_nettype none
`timescale 1ns/1ps
`include "adcri_map.svh"

module adcri_top_tb
  import adcri_pkg::*;
;
  logic i_mclk = 1'b0, i_rstn = 1'b0, i_soft_rstn = 1'b1;
  logic i_read = 1'b0, i_write = 1'b0, i_conv_done = 1'b0;
  logic [7:0] i_address = 8'h00;
  logic [3:0] i_byteenable = 4'h0;
  logic [31:0] i_writedata = 32'h00000000;
  logic [9:0] i_conv_result = 10'h000;
  logic [10:0] i_trig_src = 11'h000;
  logic o_waitrequest, o_conv_start, o_converter_on, o_conv_tick;
  logic [31:0] o_readdata;
  logic [4:0] o_channel_selector;
  logic [1:0] o_positive_reference_select;
  logic [9:0] vals [3] = '{10'h3FF, 10'h001, 10'h2A5};
  int n_errors = 0, checks = 0, cycles = 0;

  adcri_top i_adcri_top (.i_mclk, .i_rstn, .i_soft_rstn, .i_address, .i_read, .i_write,
    .i_byteenable, .i_writedata, .o_waitrequest, .o_readdata, .i_conv_done,
    .i_conv_result, .i_trig_src, .o_conv_start, .o_converter_on, .o_channel_selector,
    .o_positive_reference_select, .o_conv_tick);

  always #4 i_mclk = ~i_mclk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic final_report();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, d, input logic [3:0] be,
    output logic [7:0] q);
    @(posedge i_mclk);
    i_write <= w;
    i_read <= !w;
    i_address <= a;
    i_writedata <= {24'h000000, d};
    i_byteenable <= be;
    do @(posedge i_mclk); while (o_waitrequest !== 1'b0);
    q = o_readdata[7:0];
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    bus(1'b1, a, d, 4'h1, q);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, 4'hF, q);
    chk(nm, exp, q);
  endtask

  task automatic wait_start();
    int t;
    for (t = 0; t < 100 && o_conv_start !== 1'b1; t++) @(posedge i_mclk);
    chk("conv_start", 8'h01, {7'h00, o_conv_start});
  endtask

  task automatic ticks(input string nm, input int n, input logic [7:0] exp);
    logic [7:0] c;
    c = 8'h00;
    repeat (n) begin
      @(posedge i_mclk);
      c = c + {7'h00, o_conv_tick};
    end
    chk(nm, exp, c);
  endtask

  task automatic done(input logic [9:0] r);
    i_conv_done <= 1'b1;
    i_conv_result <= r;
    @(posedge i_mclk) i_conv_done <= 1'b0;
  endtask

  task automatic conv(input logic f, input logic [9:0] r);
    logic [7:0] eh, el;
    eh = f ? {6'h00, r[9:8]} : r[9:2];
    el = f ? r[7:0] : {r[1:0], 6'h00};
    wr(`ADCRI_OFS_FMT_CLK_REF, {f, 7'h00});
    wr(`ADCRI_OFS_RES_HIGH, 8'hFF);
    wr(`ADCRI_OFS_RES_LOW, 8'hFF);
    wr(`ADCRI_OFS_MAIN_CTRL, 8'h09);
    repeat (40) @(posedge i_mclk);
    wr(`ADCRI_OFS_MAIN_CTRL, 8'h0B);
    wait_start();
    done(r);
    rdc("main_ctrl", `ADCRI_OFS_MAIN_CTRL, 8'h09);
    rdc("result_high", `ADCRI_OFS_RES_HIGH, eh);
    rdc("result_low", `ADCRI_OFS_RES_LOW, el);
  endtask

  // ****************************************************************
  // Sequence and timeout
  // ****************************************************************
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    logic [7:0] q;
    repeat (20) @(posedge i_mclk);
    i_rstn <= 1'b1;
    rdc("main_ctrl", `ADCRI_OFS_MAIN_CTRL, 8'h00);
    rdc("trig_sel", `ADCRI_OFS_TRIG_SEL, 8'h00);
    wr(`ADCRI_OFS_MAIN_CTRL, 8'hFD);
    rdc("main_ctrl", `ADCRI_OFS_MAIN_CTRL, 8'h7D);
    chk("channel", 8'h1F, {3'h0, o_channel_selector});
    chk("on", 8'h01, {7'h00, o_converter_on});
    wr(`ADCRI_OFS_FMT_CLK_REF, 8'hFF);
    rdc("fmt_clk_ref", `ADCRI_OFS_FMT_CLK_REF, 8'hF3);
    chk("pref", 8'h03, {6'h00, o_positive_reference_select});
    wr(`ADCRI_OFS_TRIG_SEL, 8'hFF);
    rdc("trig_sel", `ADCRI_OFS_TRIG_SEL, 8'hF0);
    wr(8'h14, 8'hFF);
    rdc("unmapped", 8'h14, 8'h00);
    wr(`ADCRI_OFS_RES_HIGH, 8'hA5);
    wr(`ADCRI_OFS_RES_LOW, 8'h5A);
    bus(1'b1, `ADCRI_OFS_RES_HIGH, 8'h3C, 4'h0, q);
    @(posedge i_mclk) i_soft_rstn <= 1'b0;
    @(posedge i_mclk) i_soft_rstn <= 1'b1;
    rdc("result_high", `ADCRI_OFS_RES_HIGH, 8'hA5);
    rdc("result_low", `ADCRI_OFS_RES_LOW, 8'h5A);
    rdc("main_ctrl", `ADCRI_OFS_MAIN_CTRL, 8'h00);
    wr(`ADCRI_OFS_MAIN_CTRL, 8'h02);
    rdc("main_ctrl", `ADCRI_OFS_MAIN_CTRL, 8'h00);
    wr(`ADCRI_OFS_TRIG_SEL, 8'h10);
    wr(`ADCRI_OFS_MAIN_CTRL, 8'h01);
    repeat (40) @(posedge i_mclk);
    i_trig_src <= 11'h002;
    wait_start();
    i_trig_src <= 11'h000;
    done(10'h155);
    rdc("main_ctrl", `ADCRI_OFS_MAIN_CTRL, 8'h01);
    wr(`ADCRI_OFS_TRIG_SEL, 8'h00);
    for (int i = 0; i < 6; i++) conv(i[0], vals[i / 2]);
    // Conversion clock enable at divide by 2 and by 16, then off
    ticks("tick_div2", 8, 8'h04);
    wr(`ADCRI_OFS_FMT_CLK_REF, 8'h50);
    repeat (2) @(posedge i_mclk);
    ticks("tick_div16", 32, 8'h02);
    // Clearing go mid-conversion aborts without a load
    wr(`ADCRI_OFS_MAIN_CTRL, 8'h0B);
    wait_start();
    wr(`ADCRI_OFS_MAIN_CTRL, 8'h09);
    done(10'h3C3);
    rdc("result_high", `ADCRI_OFS_RES_HIGH, 8'h02);
    rdc("result_low", `ADCRI_OFS_RES_LOW, 8'hA5);
    wr(`ADCRI_OFS_MAIN_CTRL, 8'h00);
    repeat (2) @(posedge i_mclk);
    ticks("tick_off", 32, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
